// >>> rtl/pmcc_top.sv
// Power-mode and CPU clock controller with APB registers.
// Assumes oscillator clocks arrive as pins slower than pclk/4,
// and that CPU and interrupt logic share pclk.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

module pmcc_top #(
	parameter int FLASH_SYS_TICKS = pmcc_pkg::FLASH_SYS_TICKS,
	parameter int FLASH_US_CYC = pmcc_pkg::FLASH_US_CYC,
	parameter int RESTART_TICKS = pmcc_pkg::RESTART_TICKS,
	parameter int ISEQ_TICKS = pmcc_pkg::ISEQ_TICKS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic main_osc_clk,
	input wire logic low_osc_clk,
	input wire logic high_osc_clk,
	input wire logic wait_instruction,
	input wire logic irq_internal,
	input wire logic irq_external,
	output logic cpu_clk_en,
	output logic [4:0] divided_peripheral_clocks,
	output logic onchip_reference_clock,
	output logic onchip_reference_clock_div128,
	output logic high_speed_timer_clock,
	output logic watchdog_reference_clock,
	output logic main_osc_enable,
	output logic low_osc_enable,
	output logic high_osc_enable,
	output logic pin_hold,
	output logic irq_routine_start
);

	localparam logic [9:0] FLASH_LAST = 10'(FLASH_SYS_TICKS - 1);
	localparam logic [9:0] SETTLE_LAST = 10'(FLASH_US_CYC - 1);
	localparam logic [9:0] RESTART_LAST = 10'(RESTART_TICKS - 1);
	localparam logic [9:0] ISEQ_LAST = 10'(ISEQ_TICKS - 1);

	// ----------------------------------------
	// Registers and decoded bits
	// ----------------------------------------
	logic [7:0] clk_ctrl_q;
	logic [2:0] osc_ctrl_q;
	logic [1:0] cpu_divider_field;
	logic divide_by_eight_select;
	logic main_oscillator_stop;
	logic crystal_pin_function;
	logic low_speed_oscillator_off;
	logic peripheral_clock_stop_in_wait;
	logic system_clock_source_select;
	logic high_speed_oscillator_enable;
	logic onchip_oscillator_select;
	logic flash_stop_bit;

	assign cpu_divider_field = clk_ctrl_q[pmcc_pkg::CC_DIV_HI:pmcc_pkg::CC_DIV_LO];
	assign divide_by_eight_select = clk_ctrl_q[pmcc_pkg::CC_DIV8];
	assign main_oscillator_stop = clk_ctrl_q[pmcc_pkg::CC_MSTOP];
	assign crystal_pin_function = clk_ctrl_q[pmcc_pkg::CC_XTAL];
	assign low_speed_oscillator_off = clk_ctrl_q[pmcc_pkg::CC_LSOFF];
	assign peripheral_clock_stop_in_wait = clk_ctrl_q[pmcc_pkg::CC_STOPW];
	assign system_clock_source_select = clk_ctrl_q[pmcc_pkg::CC_SRC];
	assign high_speed_oscillator_enable = osc_ctrl_q[pmcc_pkg::OC_HSEN];
	assign onchip_oscillator_select = osc_ctrl_q[pmcc_pkg::OC_SEL];
	assign flash_stop_bit = osc_ctrl_q[pmcc_pkg::OC_FSTOP];

	// ----------------------------------------
	// Oscillator pin synchronisers
	// ----------------------------------------
	logic [2:0] osc_s1_q;
	logic [2:0] osc_s2_q;
	logic [2:0] osc_s3_q;
	logic [2:0] osc_edge;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_s1_q <= 3'h0;
			osc_s2_q <= 3'h0;
			osc_s3_q <= 3'h0;
		end else begin
			osc_s1_q <= {high_osc_clk, low_osc_clk, main_osc_clk};
			osc_s2_q <= osc_s1_q;
			osc_s3_q <= osc_s2_q;
		end
	end

	assign osc_edge = osc_s2_q & ~osc_s3_q;

	// ----------------------------------------
	// Clock source selection
	// ----------------------------------------
	logic main_tick;
	logic ls_tick;
	logic hs_tick;
	logic main_running;
	logic onchip_tick;
	logic sys_tick;

	assign main_running = crystal_pin_function & ~main_oscillator_stop; // RQ23
	assign main_tick = main_running & osc_edge[0];
	assign ls_tick = ~low_speed_oscillator_off & osc_edge[1];
	assign hs_tick = high_speed_oscillator_enable & osc_edge[2];
	assign onchip_tick = onchip_oscillator_select ? hs_tick : ls_tick; // RQ4
	assign sys_tick = system_clock_source_select ? onchip_tick : main_tick; // RQ21 RQ3

	// ----------------------------------------
	// CPU divider
	// ----------------------------------------
	logic [3:0] cpu_last;
	logic cpu_tick;

	always_comb begin
		if (divide_by_eight_select) begin
			cpu_last = pmcc_pkg::LAST_DIV8; // RQ22 RQ2
		end else begin
			unique case (cpu_divider_field)
				pmcc_pkg::FLD_DIV1: cpu_last = pmcc_pkg::LAST_DIV1; // RQ1
				pmcc_pkg::FLD_DIV2: cpu_last = pmcc_pkg::LAST_DIV2; // RQ2
				pmcc_pkg::FLD_DIV4: cpu_last = pmcc_pkg::LAST_DIV4; // RQ2
				default: cpu_last = pmcc_pkg::LAST_DIV16; // RQ2
			endcase
		end
	end

	pmcc_div #(.W(4)) u_cpu_div (
		.clk(pclk),
		.rstn(presetn),
		.tick(sys_tick),
		.last(cpu_last),
		.cnt(),
		.pulse(cpu_tick)
	);

	// ----------------------------------------
	// Peripheral and reference dividers
	// ----------------------------------------
	logic [4:0] per_cnt;
	logic [4:0] per_ticks;
	logic ref128_tick;

	pmcc_div #(.W(5)) u_per_div (
		.clk(pclk),
		.rstn(presetn),
		.tick(sys_tick),
		.last(pmcc_pkg::LAST_PER),
		.cnt(per_cnt),
		.pulse()
	);

	pmcc_div #(.W(7)) u_ref_div (
		.clk(pclk),
		.rstn(presetn),
		.tick(onchip_tick),
		.last(pmcc_pkg::LAST_REF128),
		.cnt(),
		.pulse(ref128_tick)
	);

	assign per_ticks[0] = sys_tick;
	assign per_ticks[1] = sys_tick & per_cnt[0];
	assign per_ticks[2] = sys_tick & (&per_cnt[1:0]);
	assign per_ticks[3] = sys_tick & (&per_cnt[2:0]);
	assign per_ticks[4] = sys_tick & (&per_cnt);

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] rd_data;
	logic addr_hit;
	logic apb_take;
	logic apb_wr;
	pmcc_pkg::pmcc_state_t state_q;

	assign apb_take = psel & penable & ~pready_q;
	assign apb_wr = psel & penable & pready_q & pwrite;

	always_comb begin
		rd_data = 32'h0;
		addr_hit = 1'b1;
		unique case (paddr)
			pmcc_pkg::OFF_CLK_CTRL: rd_data = {24'h0, clk_ctrl_q};
			pmcc_pkg::OFF_OSC_CTRL: rd_data = {29'h0, osc_ctrl_q};
			pmcc_pkg::OFF_STATUS: rd_data = {26'h0, main_running,
				high_speed_oscillator_enable | ~low_speed_oscillator_off, 1'b0, state_q};
			default: addr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= apb_take;
			pslverr_q <= apb_take & ~addr_hit;
			if (apb_take) begin
				prdata_q <= pwrite ? 32'h0 : rd_data;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_ctrl_q <= pmcc_pkg::CLK_CTRL_RST;
			osc_ctrl_q <= pmcc_pkg::OSC_CTRL_RST;
		end else if (apb_wr) begin
			if (paddr == pmcc_pkg::OFF_CLK_CTRL) begin
				clk_ctrl_q <= pwdata[7:0];
			end
			if (paddr == pmcc_pkg::OFF_OSC_CTRL) begin
				osc_ctrl_q <= pwdata[2:0];
			end
		end
	end

	// ----------------------------------------
	// Wait mode and wake-up sequence
	// ----------------------------------------
	logic [9:0] cnt_q;
	logic wake;
	logic cpu_run;

	assign wake = irq_external | (irq_internal & ~peripheral_clock_stop_in_wait); // RQ12 RQ14
	assign cpu_run = (state_q == pmcc_pkg::ST_RUN) | (state_q == pmcc_pkg::ST_ISEQ); // RQ9

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= pmcc_pkg::ST_RUN;
			cnt_q <= 10'h0;
		end else begin
			unique case (state_q)
				pmcc_pkg::ST_RUN: begin
					if (wait_instruction) begin
						state_q <= pmcc_pkg::ST_WAIT; // RQ11
					end
				end
				pmcc_pkg::ST_WAIT: begin
					if (wake) begin
						state_q <= pmcc_pkg::ST_FLASH;
						cnt_q <= 10'h0;
					end
				end
				pmcc_pkg::ST_FLASH: begin
					if (sys_tick) begin
						if (cnt_q == FLASH_LAST) begin
							cnt_q <= 10'h0;
							state_q <= flash_stop_bit ? pmcc_pkg::ST_RESTART
								: pmcc_pkg::ST_SETTLE; // RQ19
						end else begin
							cnt_q <= cnt_q + 10'h1;
						end
					end
				end
				pmcc_pkg::ST_SETTLE: begin
					if (cnt_q == SETTLE_LAST) begin
						cnt_q <= 10'h0;
						state_q <= pmcc_pkg::ST_RESTART; // RQ19
					end else begin
						cnt_q <= cnt_q + 10'h1;
					end
				end
				pmcc_pkg::ST_RESTART: begin
					if (cpu_tick) begin
						if (cnt_q == RESTART_LAST) begin
							cnt_q <= 10'h0;
							state_q <= pmcc_pkg::ST_ISEQ; // RQ20 RQ17
						end else begin
							cnt_q <= cnt_q + 10'h1;
						end
					end
				end
				pmcc_pkg::ST_ISEQ: begin
					if (cpu_tick) begin
						if (cnt_q == ISEQ_LAST) begin
							cnt_q <= 10'h0;
							state_q <= pmcc_pkg::ST_RUN; // RQ20
						end else begin
							cnt_q <= cnt_q + 10'h1;
						end
					end
				end
				default: begin
					state_q <= pmcc_pkg::ST_RUN;
					cnt_q <= 10'h0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Clock enable outputs
	// ----------------------------------------
	logic cpu_clk_en_q;
	logic [4:0] per_en_q;
	logic ref_en_q;
	logic ref128_en_q;
	logic fast_en_q;
	logic wdt_ref_en_q;
	logic pin_hold_q;
	logic irq_start_q;
	logic main_en_q;
	logic ls_en_q;
	logic hs_en_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_clk_en_q <= 1'b0;
			per_en_q <= 5'h0;
		end else begin
			cpu_clk_en_q <= cpu_tick & cpu_run; // RQ9 RQ18 RQ1 RQ2 RQ3
			per_en_q <= (~cpu_run & peripheral_clock_stop_in_wait) ? 5'h0 : per_ticks; // RQ10
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_en_q <= 1'b0;
			ref128_en_q <= 1'b0;
			fast_en_q <= 1'b0;
			wdt_ref_en_q <= 1'b0;
		end else begin
			ref_en_q <= onchip_tick; // RQ5
			ref128_en_q <= ref128_tick; // RQ5
			fast_en_q <= hs_tick; // RQ6
			wdt_ref_en_q <= ls_tick; // RQ7
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_hold_q <= 1'b0;
			irq_start_q <= 1'b0;
			main_en_q <= 1'b0;
			ls_en_q <= 1'b0;
			hs_en_q <= 1'b0;
		end else begin
			pin_hold_q <= ~cpu_run; // RQ11
			irq_start_q <= (state_q == pmcc_pkg::ST_ISEQ) & cpu_tick
				& (cnt_q == ISEQ_LAST); // RQ17
			main_en_q <= main_running; // RQ23
			ls_en_q <= ~low_speed_oscillator_off;
			hs_en_q <= high_speed_oscillator_enable;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign cpu_clk_en = cpu_clk_en_q;
	assign divided_peripheral_clocks = per_en_q;
	assign onchip_reference_clock = ref_en_q;
	assign onchip_reference_clock_div128 = ref128_en_q;
	assign high_speed_timer_clock = fast_en_q;
	assign watchdog_reference_clock = wdt_ref_en_q;
	assign main_osc_enable = main_en_q;
	assign low_osc_enable = ls_en_q;
	assign high_osc_enable = hs_en_q;
	assign pin_hold = pin_hold_q;
	assign irq_routine_start = irq_start_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	hs_undivided_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
		(cpu_run && !system_clock_source_select && main_running && osc_edge[0]
		&& !divide_by_eight_select && cpu_divider_field == pmcc_pkg::FLD_DIV1)
		|=> cpu_clk_en_q)
		else $error("CPU clock not undivided in high-speed mode");

	div8_force_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ22
		divide_by_eight_select |-> cpu_last == pmcc_pkg::LAST_DIV8)
		else $error("Divide-by-8 select not forcing ratio");

	cpu_stopped_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
		(state_q == pmcc_pkg::ST_WAIT) [*2] |-> !cpu_clk_en_q)
		else $error("CPU clock running in wait");

	per_gated_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
		(state_q == pmcc_pkg::ST_WAIT && peripheral_clock_stop_in_wait)
		|=> per_en_q == 5'h0)
		else $error("Peripheral clocks not gated in wait");

	int_wake_block_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
		(state_q == pmcc_pkg::ST_WAIT && peripheral_clock_stop_in_wait
		&& !irq_external) |=> state_q == pmcc_pkg::ST_WAIT)
		else $error("Internal interrupt woke with clocks stopped");

	ext_wake_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
		(state_q == pmcc_pkg::ST_WAIT && irq_external)
		|=> state_q == pmcc_pkg::ST_FLASH ##1 pin_hold_q)
		else $error("External interrupt did not wake");

	settle_skip_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ19
		$rose(state_q == pmcc_pkg::ST_SETTLE) |-> !$past(flash_stop_bit)
		&& $past(cnt_q) == FLASH_LAST)
		else $error("Flash settle entered wrongly");

	settle_len_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ19
		$fell(state_q == pmcc_pkg::ST_SETTLE) |-> $past(cnt_q) == SETTLE_LAST)
		else $error("Flash settle length wrong");

	restart_len_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ20
		$rose(state_q == pmcc_pkg::ST_ISEQ) |-> $past(cnt_q) == RESTART_LAST
		&& $past(cpu_tick))
		else $error("CPU restart length wrong");

	irq_start_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
		irq_start_q |-> $past(state_q) == pmcc_pkg::ST_ISEQ
		&& state_q == pmcc_pkg::ST_RUN)
		else $error("Interrupt routine start out of sequence");

	wdt_ref_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
		(!low_speed_oscillator_off && osc_edge[1]) |=> wdt_ref_en_q)
		else $error("Watchdog reference clock missing");

endmodule

// >>> include/pmcc_pkg.sv
// Constants, register map and state type of the power-mode clock controller.
// Assumes a 20 MHz pclk and a 32-bit APB master on the register side.
//
// How it works
// (RQ1) Main clock, field 00b, no divide-by-8, oscillator running: CPU clock undivided.
// (RQ2) Main clock divided by 2, 4, 16 from field, or 8 when divide-by-8 set.
// (RQ3) On-chip clock as source uses same division and also feeds peripheral clocks.
// (RQ4) On-chip clock is low-speed when select 0, high-speed when select 1.
// (RQ5) Reference clock and its divide-by-128 go to timers when an on-chip oscillator runs.
// (RQ6) Fast timer clock comes from high-speed oscillator whenever it is enabled.
// (RQ7) Watchdog reference clock runs whenever the low-speed oscillator is on.
// (RQ8) Software switches source only once the new source oscillates stably.
// (RQ9) In wait the CPU clock stops while oscillators and their peripherals keep running.
// (RQ10) Stop-in-wait bit set gates divided peripheral clocks off during wait.
// (RQ11) Wait instruction enters wait; pins are held for the whole wait.
// (RQ12) Wait ends on hardware reset or an enabled peripheral interrupt.
// (RQ13) For reset wake-up, software disables every peripheral interrupt first.
// (RQ14) Any interrupt wakes with stop bit 0; only externally clocked ones with bit 1.
// (RQ15) With clocks stopped, software uses external interrupts 0 and 3 only unfiltered.
// (RQ16) Software sets levels, global enable, then starts the waking peripheral.
// (RQ17) Interrupt sequence runs once request raised and CPU clock restarted.
// (RQ18) After wake the CPU clock keeps the source and division of wait entry.
// (RQ19) Flash activation lasts 12 system clocks plus 30 us unless flash stopped.
// (RQ20) CPU clock restart takes 6 CPU clocks, interrupt sequence 20 more.
// (RQ21) Source select 0 picks the main clock, 1 the on-chip clock.
// (RQ22) Divider field acts only with divide-by-8 clear; set forces divide by 8.
// (RQ23) Main oscillator runs when stop is clear and crystal pin function is set.

package pmcc_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_CLK_CTRL = 8'h00;
	localparam logic [7:0] OFF_OSC_CTRL = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CC_DIV_LO = 0;
	localparam int CC_DIV_HI = 1;
	localparam int CC_DIV8 = 2;
	localparam int CC_MSTOP = 3;
	localparam int CC_XTAL = 4;
	localparam int CC_LSOFF = 5;
	localparam int CC_STOPW = 6;
	localparam int CC_SRC = 7;
	localparam int OC_HSEN = 0;
	localparam int OC_SEL = 1;
	localparam int OC_FSTOP = 2;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] CLK_CTRL_RST = 8'h8c;
	localparam logic [2:0] OSC_CTRL_RST = 3'h0;

	// ----------------------------------------
	// Division codes
	// ----------------------------------------
	localparam logic [1:0] FLD_DIV1 = 2'h0;
	localparam logic [1:0] FLD_DIV2 = 2'h1;
	localparam logic [1:0] FLD_DIV4 = 2'h2;
	localparam logic [3:0] LAST_DIV1 = 4'h0;
	localparam logic [3:0] LAST_DIV2 = 4'h1;
	localparam logic [3:0] LAST_DIV4 = 4'h3;
	localparam logic [3:0] LAST_DIV8 = 4'h7;
	localparam logic [3:0] LAST_DIV16 = 4'hf;
	localparam logic [4:0] LAST_PER = 5'h1f;
	localparam logic [6:0] LAST_REF128 = 7'h7f;

	// ----------------------------------------
	// Wake-up timing
	// ----------------------------------------
	localparam int PCLK_MHZ = 20;
	localparam int FLASH_SYS_TICKS = 12;
	localparam int FLASH_ACT_US = 30;
	localparam int FLASH_US_CYC = FLASH_ACT_US * PCLK_MHZ;
	localparam int RESTART_TICKS = 6;
	localparam int ISEQ_TICKS = 20;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_WAIT,
		ST_FLASH,
		ST_SETTLE,
		ST_RESTART,
		ST_ISEQ
	} pmcc_state_t;

endpackage

// >>> rtl/pmcc_div.sv
// Tick divider: counts enable ticks and pulses on the last one.
// Assumes the tick is a one-cycle enable on the same clock.
`timescale 1ns/1ps

module pmcc_div #(
	parameter int W = 4
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic tick,
	input wire logic [W-1:0] last,
	output logic [W-1:0] cnt,
	output logic pulse
);

	logic [W-1:0] cnt_q;
	logic wrap;

	// Greater-or-equal keeps a shortened ratio from running away
	assign wrap = (cnt_q >= last);
	assign pulse = tick & wrap;
	assign cnt = cnt_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= '0;
		end else if (tick) begin
			if (wrap) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

endmodule

// >>> tb/tb_power_mode_clock_control.sv
// Self-checking bench for the power-mode clock controller (pmcc_top).
// Assumes pmcc_pkg is compiled first; drives APB and oscillator pins itself.
`timescale 1ns/1ps

module tb_power_mode_clock_control;
	// ----------------------------------------
	// Signals and design
	// ----------------------------------------
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, main_osc_clk = 1'b0, low_osc_clk = 1'b0, high_osc_clk = 1'b0;
	logic wait_instruction = 1'b0, irq_internal = 1'b0, irq_external = 1'b0;
	logic cpu_clk_en, ref_clk, ref128, hs_clk, wd_clk, main_en, low_en, high_en, pin_hold, isr;
	logic [4:0] per_clk;
	logic [5:0] mon;
	logic [31:0] rd;
	logic err;
	int n_fail = 0, check_count = 0, p, n, d0, d1, i;
	int mc = 0, lc = 0, hc = 0;
	int tbl [6][3] = '{'{0, 0, 1}, '{1, 0, 2}, '{2, 0, 4}, '{3, 0, 16}, '{0, 1, 8}, '{3, 1, 8}};

	assign mon = {per_clk[0], wd_clk, hs_clk, ref128, ref_clk, cpu_clk_en};

	pmcc_top #(.FLASH_US_CYC(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .main_osc_clk(main_osc_clk),
		.low_osc_clk(low_osc_clk), .high_osc_clk(high_osc_clk),
		.wait_instruction(wait_instruction), .irq_internal(irq_internal),
		.irq_external(irq_external), .cpu_clk_en(cpu_clk_en),
		.divided_peripheral_clocks(per_clk), .onchip_reference_clock(ref_clk),
		.onchip_reference_clock_div128(ref128), .high_speed_timer_clock(hs_clk),
		.watchdog_reference_clock(wd_clk), .main_osc_enable(main_en),
		.low_osc_enable(low_en), .high_osc_enable(high_en), .pin_hold(pin_hold),
		.irq_routine_start(isr));

	// ----------------------------------------
	// Clock and oscillators (main 10, low 8, high 6 pclk periods)
	// ----------------------------------------
	initial begin
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		mc <= (mc + 1) % 10;
		lc <= (lc + 1) % 8;
		hc <= (hc + 1) % 6;
		main_osc_clk <= (mc < 5);
		low_osc_clk <= (lc < 4);
		high_osc_clk <= (hc < 3);
	end

	// ----------------------------------------
	// Checks and closing
	// ----------------------------------------
	task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
		check_count++;
		if (g < lo || g > hi) begin
			n_fail++;
			$display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge pclk);
		n_fail++;
		end_sim;
	end

	// ----------------------------------------
	// APB master and monitors
	// ----------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (k == 20) begin
			n_fail++;
			end_sim;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic period(input int idx, output int per);
		int k;
		per = 0;
		for (k = 0; k < 4000 && mon[idx] !== 1'b1; k++) @(negedge pclk);
		@(negedge pclk);
		for (k = 1; k < 4000 && mon[idx] !== 1'b1; k++) @(negedge pclk);
		per = k;
		if (k >= 4000) begin
			n_fail++;
			end_sim;
		end
	endtask
	task automatic count(input int idx, input int cyc, output int cnt);
		cnt = 0;
		repeat (cyc) begin
			@(negedge pclk);
			if (mon[idx] === 1'b1) cnt++;
		end
	endtask
	task automatic cpu_per(input logic [31:0] cc, input int exp);
		apb(1'b1, pmcc_pkg::OFF_CLK_CTRL, cc);
		period(0, p);
		period(0, p);
		chk_rng("cpu period", exp, exp, p);
	endtask
	// Enter wait, probe gating, wake by the chosen request, return wake time
	task automatic do_wait(input logic stopw, input logic ext, output int dur);
		@(posedge pclk);
		wait_instruction <= 1'b1;
		@(posedge pclk);
		wait_instruction <= 1'b0;
		repeat (4) @(posedge pclk);
		chk32("pin_hold", 32'h1, {31'h0, pin_hold});
		count(0, 100, n);
		chk_rng("cpu ticks in wait", 0, 0, n);
		count(5, 100, n);
		chk_rng("f1 ticks in wait", stopw ? 0 : 12, stopw ? 0 : 13, n);
		count(1, 100, n);
		chk_rng("ref ticks in wait", 12, 13, n);
		if (stopw) begin
			@(posedge pclk);
			irq_internal <= 1'b1;
			repeat (40) @(posedge pclk);
			chk32("pin_hold refused", 32'h1, {31'h0, pin_hold});
			irq_internal <= 1'b0;
		end
		@(posedge pclk);
		if (ext) irq_external <= 1'b1;
		else irq_internal <= 1'b1;
		for (dur = 0; dur < 2000 && isr !== 1'b1; dur++) @(negedge pclk);
		if (dur >= 2000) begin
			n_fail++;
			end_sim;
		end
		@(posedge pclk);
		irq_external <= 1'b0;
		irq_internal <= 1'b0;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, pmcc_pkg::OFF_CLK_CTRL, 32'h0);
		chk32("clk_ctrl reset", {24'h0, pmcc_pkg::CLK_CTRL_RST}, rd);
		apb(1'b0, pmcc_pkg::OFF_OSC_CTRL, 32'h0);
		chk32("osc_ctrl reset", 32'h0, rd);
		apb(1'b0, pmcc_pkg::OFF_STATUS, 32'h0);
		chk32("status reset", 32'h10, rd);
		apb(1'b0, 8'h0c, 32'h0);
		chk32("unmapped read", 32'h0, rd);
		chk32("unmapped err", 32'h1, {31'h0, err});
		apb(1'b1, pmcc_pkg::OFF_OSC_CTRL, 32'hffff_fffc);
		apb(1'b0, pmcc_pkg::OFF_OSC_CTRL, 32'h0);
		chk32("osc_ctrl width", 32'h4, rd);
		// Low-speed on-chip source, every division code
		apb(1'b1, pmcc_pkg::OFF_OSC_CTRL, 32'h0);
		for (i = 0; i < 6; i++) begin
			cpu_per({24'h0, 5'h10, tbl[i][1] != 0, tbl[i][0][1:0]}, 8 * tbl[i][2]);
		end
		period(5, p);
		chk_rng("f1 from on-chip", 8, 8, p);
		// Main clock source
		apb(1'b1, pmcc_pkg::OFF_CLK_CTRL, 32'h90);
		repeat (20) @(posedge pclk);
		apb(1'b1, pmcc_pkg::OFF_CLK_CTRL, 32'h10);
		repeat (2) @(negedge pclk);
		chk32("main enable", 32'h1, {31'h0, main_en});
		for (i = 0; i < 6; i++) begin
			cpu_per({24'h0, 5'h02, tbl[i][1] != 0, tbl[i][0][1:0]}, 10 * tbl[i][2]);
		end
		cpu_per(32'h10, 10);
		period(1, p);
		chk_rng("ref low", 8, 8, p);
		count(3, 60, n);
		chk_rng("fast off", 0, 0, n);
		// High-speed on-chip oscillator selected
		apb(1'b1, pmcc_pkg::OFF_OSC_CTRL, 32'h3);
		period(3, p);
		chk_rng("fast timer", 6, 6, p);
		period(2, p);
		chk_rng("ref128", 768, 768, p);
		cpu_per(32'h81, 12);
		period(4, p);
		chk_rng("watchdog ref", 8, 8, p);
		apb(1'b1, pmcc_pkg::OFF_CLK_CTRL, 32'h30);
		repeat (2) @(negedge pclk);
		chk32("low enable off", 32'h0, {31'h0, low_en});
		count(4, 60, n);
		chk_rng("watchdog off", 0, 0, n);
		// Wait with peripheral clocks stopped, external wake
		apb(1'b1, pmcc_pkg::OFF_OSC_CTRL, 32'h0);
		cpu_per(32'hc0, 8);
		do_wait(1'b1, 1'b1, d0);
		chk_rng("wake time", 38 * 8 + 4 - 16, 38 * 8 + 4 + 16, d0);
		@(posedge pclk);
		chk32("pin released", 32'h0, {31'h0, pin_hold});
		period(0, p);
		period(0, p);
		chk_rng("cpu after wake", 8, 8, p);
		// Wait with peripheral clocks running, internal wake, flash stopped
		apb(1'b1, pmcc_pkg::OFF_OSC_CTRL, 32'h4);
		cpu_per(32'h81, 16);
		do_wait(1'b0, 1'b0, d1);
		chk_rng("wake time fstop", 12 * 8 + 26 * 16 - 24, 12 * 8 + 26 * 16 + 24, d1);
		period(0, p);
		period(0, p);
		chk_rng("cpu after wake 2", 16, 16, p);
		// Hardware reset ends wait
		@(posedge pclk);
		wait_instruction <= 1'b1;
		@(posedge pclk);
		wait_instruction <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk32("pin after reset", 32'h0, {31'h0, pin_hold});
		apb(1'b0, pmcc_pkg::OFF_STATUS, 32'h0);
		chk32("status after reset", 32'h10, rd);
		end_sim;
	end
endmodule
